// ===== logic/atahp_pkg.sv
package atahp_pkg;
  // Clock period
  localparam int CLK_NS      = 4;
  // Bus timing figures in ns
  localparam int SETUP_NS    = 25;
  localparam int WIDTH_NS    = 70;
  localparam int HOLD_NS     = 10;
  localparam int RECOVER_NS  = 25;
  localparam int CYCLE_NS    = 120;
  // Least times rounded up to whole clocks
  localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIDTH_CYC   = (WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYCLE_CYC   = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  // Register addresses
  localparam logic [2:0] DATA_ADDR    = 3'h0;
  localparam logic [2:0] CONTROL_ADDR = 3'h6;
  localparam logic [2:0] DRIVE_ADDR   = 3'h7;
  // Reset values
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  // Transfer phases
  typedef enum logic [2:0] {
    ATAHP_IDLE,
    ATAHP_SETUP,
    ATAHP_ACTIVE,
    ATAHP_HOLD,
    ATAHP_RECOVER
  } atahp_phase_e;
endpackage

// ===== logic/atahp_sync_if.sv
`timescale 1ns/10ps
// Raw pin samples in, filtered levels out
interface atahp_sync_if #(parameter int W = 17);
  logic [W-1:0] raw;     // Asynchronous pin levels
  logic [W-1:0] stable;  // Filtered, clock-domain levels
  modport filter (input raw, output stable);
  modport user   (output raw, input stable);
endinterface

// ===== logic/atahp_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser with agreement filter
module atahp_sync #(
  parameter int W = 17
) (
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst_n,
  // Pin samples
  atahp_sync_if.filter pins
);
  // All state of the synchroniser
  typedef struct packed {
    logic [W-1:0] s1;      // First stage, read only by s2
    logic [W-1:0] s2;      // Second stage
    logic [W-1:0] s3;      // Third stage
    logic [W-1:0] stable;  // Last agreed level
  } atahp_sync_s;

  atahp_sync_s st;
  atahp_sync_s next_st;

  // Shift and accept a level once stages two and three agree
  always_comb begin
    next_st        = st;
    next_st.s1     = pins.raw;
    next_st.s2     = st.s1;
    next_st.s3     = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.stable[i] = st.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign pins.stable = st.stable;
endmodule // atahp_sync

// ===== logic/atahp_host.sv
`timescale 1ns/10ps
// Host-side register access port controller
module atahp_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // User request
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_control,
  input  wire logic [2:0]  req_address,
  input  wire logic [15:0] req_wdata,
  input  wire logic [15:0] min_cycle_ns,
  // User answer
  output logic             req_ready,
  output logic             done,
  output logic             refused,
  output logic [15:0]      rd_data,
  output logic             word_cycle_seen,
  // Device pins
  output logic             primary_select_n,
  output logic             secondary_select_n,
  output logic [2:0]       register_address,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic [15:0]      data_out,
  output logic             data_oe_low,
  output logic             data_oe_high,
  input  wire logic [15:0] data_in,
  input  wire logic        word_cycle_indicator_n
);
  import atahp_pkg::*;

  // Reported cycle time in ns to whole clocks, rounded up
  function automatic logic [15:0] ns_to_cyc(input logic [15:0] ns);
    logic [16:0] sum;
    sum = {1'b0, ns} + 17'(CLK_NS - 1);
    return 16'(sum / 17'(CLK_NS));
  endfunction

  // All state of the controller
  typedef struct packed {
    atahp_phase_e phase;       // Transfer phase
    logic [7:0]   cnt;         // Phase counter
    logic [15:0]  cyc;         // Clocks since cycle start
    logic [15:0]  need;        // Clocks the whole cycle must last
    logic         write;       // Latched direction
    logic         word;        // Latched word access
    logic         ready;
    logic         done;
    logic         refused;
    logic [15:0]  rd_data;
    logic         word_seen;
    logic         psel_n;
    logic         ssel_n;
    logic [2:0]   addr;
    logic         rd_n;
    logic         wr_n;
    logic [15:0]  dout;
    logic         oe_low;
    logic         oe_high;
  } atahp_host_s;

  atahp_host_s st;
  atahp_host_s next_st;

  // Synchronised data lanes and word-cycle indicator
  atahp_sync_if #(.W(17)) sync_pins ();
  assign sync_pins.raw = {word_cycle_indicator_n, data_in};

  atahp_sync #(.W(17)) u_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .pins (sync_pins)
  );

  // Filtered pin levels and request decode
  logic [15:0] din_s;        // Filtered data lanes
  logic        word_ind_n_s; // Filtered word indicator
  logic        legal;        // Request is a documented access
  logic [15:0] rep_cyc;      // Reported minimum in clocks

  assign din_s        = sync_pins.stable[15:0];
  assign word_ind_n_s = sync_pins.stable[16];
  assign rep_cyc      = ns_to_cyc(min_cycle_ns);

  // Legal accesses: any task-file address, control write at 6, control read at 6 or 7
  function automatic logic is_legal(input logic wr, input logic ctl, input logic [2:0] addr);
    logic ok;
    if (!ctl) begin
      ok = 1'b1;
    end else if (wr) begin
      ok = (addr == CONTROL_ADDR);
    end else begin
      ok = (addr == CONTROL_ADDR) || (addr == DRIVE_ADDR);
    end
    return ok;
  endfunction

  // Illegal requests are refused before any pin moves
  assign legal = is_legal(req_write, req_control, req_address);

  // Phase sequencing and pin control
  always_comb begin
    next_st         = st;
    next_st.done    = 1'b0;
    next_st.refused = 1'b0;
    if (st.phase != ATAHP_IDLE) begin
      next_st.cyc = st.cyc + 16'h0001;
    end
    case (st.phase)
      ATAHP_IDLE: begin
        // Selects high, strobes high, bus released
        if (req_valid && st.ready) begin
          if (!legal) begin
            next_st.refused = 1'b1;
          end else begin
            next_st.ready  = 1'b0;
            next_st.write  = req_write;
            next_st.word   = !req_control && (req_address == DATA_ADDR);
            // Exactly one select low, never both
            next_st.psel_n = req_control;
            next_st.ssel_n = !req_control;
            next_st.addr   = req_address;
            // Writes drive low lanes; upper lanes only for data words
            next_st.dout    = req_wdata;
            next_st.oe_low  = req_write;
            next_st.oe_high = req_write && !req_control && (req_address == DATA_ADDR);
            next_st.cnt     = 8'(SETUP_CYC - 1);
            next_st.cyc     = 16'h0000;
            next_st.need    = (rep_cyc > 16'(CYCLE_CYC)) ? rep_cyc : 16'(CYCLE_CYC);
            next_st.phase   = ATAHP_SETUP;
          end
        end
      end
      ATAHP_SETUP: begin
        // Address setup before the strobe
        if (st.cnt == 8'h00) begin
          next_st.rd_n  = st.write;
          next_st.wr_n  = !st.write;
          next_st.cnt   = 8'(WIDTH_CYC - 1);
          next_st.phase = ATAHP_ACTIVE;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      ATAHP_ACTIVE: begin
        // Strobe low for the least width
        if (st.cnt == 8'h00) begin
          next_st.rd_n = 1'b1;
          next_st.wr_n = 1'b1;
          if (!st.write) begin
            // Byte reads keep only the low lanes
            next_st.rd_data = st.word ? din_s : {8'h00, din_s[7:0]};
          end
          next_st.word_seen = st.word && !word_ind_n_s;
          next_st.cnt       = 8'(HOLD_CYC - 1);
          next_st.phase     = ATAHP_HOLD;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      ATAHP_HOLD: begin
        // Address and write data held past the rising strobe
        if (st.cnt == 8'h00) begin
          next_st.psel_n  = 1'b1;
          next_st.ssel_n  = 1'b1;
          next_st.oe_low  = 1'b0;
          next_st.oe_high = 1'b0;
          next_st.cnt     = 8'(RECOVER_CYC - 1);
          next_st.phase   = ATAHP_RECOVER;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      ATAHP_RECOVER: begin
        // Strobe inactive time, and whole cycle no shorter than reported
        if (st.cnt != 8'h00) begin
          next_st.cnt = st.cnt - 8'h01;
        end else if (st.cyc >= st.need - 16'h0001) begin
          next_st.done  = 1'b1;
          next_st.ready = 1'b1;
          next_st.phase = ATAHP_IDLE;
        end
      end
      default: begin
        next_st.phase = ATAHP_IDLE;
      end
    endcase
  end

  // State register; idle values put the bus in standby
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st         <= '0;
      st.phase   <= ATAHP_IDLE;
      st.ready   <= 1'b1;
      st.psel_n  <= 1'b1;
      st.ssel_n  <= 1'b1;
      st.rd_n    <= 1'b1;
      st.wr_n    <= 1'b1;
      st.rd_data <= DATA_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  // User answer
  assign req_ready          = st.ready;
  assign done               = st.done;
  assign refused            = st.refused;
  assign rd_data            = st.rd_data;
  assign word_cycle_seen    = st.word_seen;
  // Device pins
  assign primary_select_n   = st.psel_n;
  assign secondary_select_n = st.ssel_n;
  assign register_address   = st.addr;
  assign read_strobe_n      = st.rd_n;
  assign write_strobe_n     = st.wr_n;
  assign data_out           = st.dout;
  assign data_oe_low        = st.oe_low;
  assign data_oe_high       = st.oe_high;
endmodule // atahp_host

// ===== test/atahp_host_checker.sv
`timescale 1ns/10ps
// Pin protocol checks on the host port
module atahp_host_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Watched outputs
  input wire logic        req_ready,
  input wire logic        refused,
  input wire logic        primary_select_n,
  input wire logic        secondary_select_n,
  input wire logic [2:0]  register_address,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic [15:0] data_out,
  input wire logic        data_oe_low,
  input wire logic        data_oe_high
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_no_dual_select:
    assert property (primary_select_n || secondary_select_n) else $error("dual select");
  a_idle_released:
    assert property (req_ready |-> primary_select_n && secondary_select_n && !data_oe_low) else $error("idle bus");
  a_strobe_one_select:
    assert property (!(read_strobe_n && write_strobe_n) |-> primary_select_n != secondary_select_n)
      else $error("strobe select");
  a_read_released:
    assert property (!read_strobe_n |-> !data_oe_low && !data_oe_high) else $error("read contention");
  a_control_address:
    assert property (!secondary_select_n |-> register_address[2:1] == 2'h3) else $error("control address");
  a_upper_word_only:
    assert property (data_oe_high |-> !primary_select_n && register_address == 3'h0) else $error("upper lanes");
  a_write_hold:
    assert property (!write_strobe_n |=> $stable(data_out) && data_oe_low) else $error("write hold");
  a_refused_quiet:
    assert property (refused |-> primary_select_n && secondary_select_n && read_strobe_n && write_strobe_n)
      else $error("refused pins");
  // Main scenarios reached
  c_write: cover property ($fell(write_strobe_n));
  c_read: cover property ($fell(read_strobe_n));
  c_refused: cover property (refused);
  c_word_write: cover property (!write_strobe_n && data_oe_high);
endmodule // atahp_host_checker

bind atahp_host atahp_host_checker u_chk (.clk, .rst_n, .req_ready, .refused, .primary_select_n,
  .secondary_select_n, .register_address, .read_strobe_n, .write_strobe_n, .data_out, .data_oe_low,
  .data_oe_high);

// ===== test/atahp_device_model.sv
`timescale 1ns/10ps
// Behavioural device behind the host port
module atahp_device_model #(
  parameter logic [7:0] STATUS = 8'h50,  // Status byte
  parameter logic [7:0] DRIVE  = 8'h00   // Drive address byte
) (
  // Host-driven pins
  input wire logic        primary_select_n,
  input wire logic        secondary_select_n,
  input wire logic [2:0]  register_address,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic [15:0] data_out,
  input wire logic        data_oe_low,
  input wire logic        data_oe_high,
  // Device-driven pins
  output logic [15:0]     data_in,
  output logic            word_cycle_indicator_n
);
  logic [7:0]  tf [8] = '{default: 8'h00};  // Task file bytes
  logic [7:0]  ctl = 8'h00;                  // Device control
  logic [15:0] word = 16'h0000;              // Data register
  logic [15:0] last = 16'h0000;              // Last driven value
  // Decoded selects; other combinations are idle or invalid
  wire tsel = secondary_select_n && !primary_select_n;
  wire csel = !secondary_select_n && primary_select_n;
  // Lanes the host leaves undriven read back inverted
  wire [7:0] lane_lo = data_oe_low ? data_out[7:0] : ~data_out[7:0];
  wire [7:0] lane_hi = data_oe_high ? data_out[15:8] : ~data_out[15:8];
  // Capture on the trailing write edge
  always @(posedge write_strobe_n) begin
    if (tsel && register_address == 3'h0) word = {lane_hi, lane_lo};
    else if (tsel) tf[register_address] = lane_lo;
    else if (csel && register_address == 3'h6) ctl = lane_lo;
  end
  // Keep last value so released lanes never echo it
  always @(posedge read_strobe_n) last = data_in;
  // Read drive; released lanes show the inverse pattern
  always @* begin
    data_in = ~last;
    if (!read_strobe_n && tsel && register_address == 3'h0) data_in = word;
    else if (!read_strobe_n && tsel) data_in[7:0] = register_address == 3'h7 ? STATUS : tf[register_address];
    else if (!read_strobe_n && csel && register_address == 3'h6) data_in[7:0] = STATUS;
    else if (!read_strobe_n && csel && register_address == 3'h7) data_in[7:0] = DRIVE;
  end
  // Word cycle flag for the data register
  assign word_cycle_indicator_n = !(tsel && register_address == 3'h0);
endmodule // atahp_device_model

// ===== test/ata_pio_register_access_port_test.sv
`timescale 1ns/10ps
// Self-checking bench for the host port
module ata_pio_register_access_port_test;
  localparam logic [7:0] ST = 8'h50;  // Status byte
  localparam logic [7:0] DA = 8'h3c;  // Drive address byte
  // Bench inputs
  logic        clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_control = 0;
  logic [2:0]  req_address = 3'h0;
  logic [15:0] req_wdata = 16'h0000, min_cycle_ns = 16'h0000;
  // Outputs and pins
  logic        req_ready, done, refused, word_cycle_seen, primary_select_n, secondary_select_n;
  logic        read_strobe_n, write_strobe_n, data_oe_low, data_oe_high, word_cycle_indicator_n;
  logic [2:0]  register_address;
  logic [15:0] rd_data, data_out, data_in;
  int          fails = 0, n_compared = 0, n;
  atahp_host dut (.clk, .rst_n, .req_valid, .req_write, .req_control, .req_address, .req_wdata,
    .min_cycle_ns, .req_ready, .done, .refused, .rd_data, .word_cycle_seen, .primary_select_n,
    .secondary_select_n, .register_address, .read_strobe_n, .write_strobe_n, .data_out,
    .data_oe_low, .data_oe_high, .data_in, .word_cycle_indicator_n);
  atahp_device_model #(.STATUS(ST), .DRIVE(DA)) model (.primary_select_n, .secondary_select_n,
    .register_address, .read_strobe_n, .write_strobe_n, .data_out, .data_oe_low, .data_oe_high, .data_in,
    .word_cycle_indicator_n);
  initial forever #2 clk = ~clk;
  // Verdict
  task automatic stop_test();
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // One request; n counts clocks to done or refused
  task automatic op(input logic w, c, input logic [2:0] a, input logic [15:0] d, mc);
    @(negedge clk);
    {req_valid, req_write, req_control, req_address, req_wdata, min_cycle_ns} = {1'b1, w, c, a, d, mc};
    @(negedge clk);
    req_valid = 0;
    for (n = 1; n < 300 && done !== 1'b1 && refused !== 1'b1; n++) @(negedge clk);
    if (n >= 300) begin
      fails++;
      stop_test();
    end
  endtask
  // Byte registers, upper byte junk on write
  task automatic t_taskfile();
    for (int a = 1; a < 7; a++) begin
      op(1, 0, 3'(a), {8'hc3, 8'(8'h10 + a)}, 0);
      chk("tf cycle", 16'h0001, 16'(n > 30));
      op(0, 0, 3'(a), 16'h0000, 0);
      chk("tf read", {8'h00, 8'(8'h10 + a)}, rd_data);
    end
    op(0, 0, 3'h7, 16'h0000, 0);
    chk("status", {8'h00, ST}, rd_data);
  endtask
  // Data register words
  task automatic t_word();
    op(1, 0, 3'h0, 16'h5aa5, 0);
    op(0, 0, 3'h0, 16'h0000, 0);
    chk("word", 16'h5aa5, rd_data);
    chk("word flag", 16'h0001, {15'h0, word_cycle_seen});
    op(0, 0, 3'h2, 16'h0000, 0);
    chk("byte flag", 16'h0000, {15'h0, word_cycle_seen});
  endtask
  // Control block and two refused requests, a write and a read
  task automatic t_control();
    op(1, 1, 3'h6, 16'hff0a, 0);
    chk("control", 16'h000a, {8'h00, model.ctl});
    op(0, 1, 3'h6, 16'h0000, 0);
    chk("alt status", {8'h00, ST}, rd_data);
    op(0, 1, 3'h7, 16'h0000, 0);
    chk("drive addr", {8'h00, DA}, rd_data);
    op(1, 1, 3'h5, 16'h0055, 0);
    chk("refused", 16'h0001, {15'h0, refused});
    chk("control kept", 16'h000a, {8'h00, model.ctl});
    op(0, 1, 3'h4, 16'h0000, 0);
    chk("refused read", 16'h0001, {15'h0, refused});
    chk("read kept", {8'h00, DA}, rd_data);
  endtask
  // Reported minimum cycle stretches the cycle
  task automatic t_cycle();
    op(0, 0, 3'h1, 16'h0000, 16'd200);
    chk("long cycle", 16'h0001, 16'(n > 50));
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    t_taskfile();
    t_word();
    t_control();
    t_cycle();
    stop_test();
  end
endmodule // ata_pio_register_access_port_test
